//--- gacd_decoder.sv
// command decoder for the aiding/host packet link: takes framed command bytes, emits ids of replies
// assumes framing upstream marks first byte with i_rx_sop and last with i_rx_eop, one byte per valid
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: aiding mode 1 sends time request 2E-00
// RULE2: aiding mode 1 sends position request 32-00
// RULE3: rollover date command sets base week date
// RULE4: host never sends date before firmware build
// RULE5: cartesian position, three single floats accepted
// RULE6: single and double position forms accepted
// RULE7: position command aborts running survey immediately
// RULE8: position command forces over-determined timing mode
// RULE9: geodetic position in radians and meters accepted
// RULE10: host gives geodetic position in world datum
// RULE11: supplied position fixes time-only solutions
// RULE12: empty options command reports states unchanged
// RULE13: four option bytes applied, then reported
// RULE14: position option byte bits decoded
// RULE15: velocity and auxiliary option bits decoded
// RULE16: host keeps world datum for geoid altitude
// RULE17: options saved to flash only on 8E-26
// RULE18: last-position request sends enabled reports, 57
// RULE19: satellite request: id 38, op 1, type 2-6
// RULE20: satellite selector 0, 1-32 or FF; code accepts FF only with type 2 (almanac) or 6 (ephemeris)
// RULE21: wrong-length position command ignored entirely
module gacd_decoder
   import gacd_pkg::*;
(
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic         i_rx_valid,
   input  wire logic         i_rx_sop,
   input  wire logic         i_rx_eop,
   input  wire logic [7:0]   i_rx_data,
   input  wire logic         i_tx_ready,
   input  wire logic         i_aid_mode,
   input  wire logic         i_aid_time_go,
   input  wire logic         i_aid_pos_go,
   input  wire logic         i_survey_active,
   output logic              o_tx_valid,
   output logic      [7:0]   o_tx_data,
   output logic              o_rx_ready,
   output logic              o_survey_abort,
   output logic              o_od_timing_mode,
   output logic              o_pos_valid,
   output logic              o_pos_is_lla,
   output logic              o_pos_is_double,
   output logic      [63:0]  o_pos_a,
   output logic      [63:0]  o_pos_b,
   output logic      [63:0]  o_pos_c,
   output logic              o_rollover_load,
   output logic      [15:0]  o_week_rollover_base_year,
   output logic      [39:0]  o_week_rollover_base_mdhms,
   output logic      [7:0]   o_opt_position,
   output logic      [7:0]   o_opt_velocity,
   output logic      [7:0]   o_opt_timing,
   output logic      [7:0]   o_opt_auxiliary,
   output logic              o_opt_save,
   output logic              o_sat_req,
   output logic      [7:0]   o_sat_type,
   output logic      [7:0]   o_sat_prn,
   output logic              o_sat_all
);
   typedef enum {ST_IDLE, ST_RECV, ST_READ, ST_EXEC, ST_WAIT} gacd_state_t;
   gacd_state_t state_q;

   logic [7:0]   id_q;
   logic [5:0]   len_q;
   logic [5:0]   rd_idx_q;
   logic [7:0]   rbuf [LEN_MAX];
   logic [7:0]   buf_rdata;
   logic         rd_pend_q;
   logic         over_q;
   logic         tx_load_q;
   logic [47:0]  tx_list_q;
   logic [2:0]   tx_count_q;
   logic         tx_busy;
   logic         tx_valid_w;
   logic [7:0]   tx_data_w;
   logic         wr_en;
   logic         aid_time_pend_q;
   logic         aid_pos_pend_q;

   assign wr_en = i_rx_valid && o_rx_ready && !i_rx_sop && len_q < LEN_MAX;

   gacd_rx_buf #(.DEPTH(24), .AW(5)) u_buf (
      .i_clock (i_clock),
      .i_we    (wr_en),
      .i_waddr (len_q[4:0]),
      .i_wdata (i_rx_data),
      .i_raddr (rd_idx_q[4:0]),
      .o_rdata (buf_rdata)
   );

   gacd_tx_seq u_tx (
      .i_clock    (i_clock),
      .i_rst      (i_rst),
      .i_load     (tx_load_q),
      .i_list     (tx_list_q),
      .i_count    (tx_count_q),
      .i_tx_ready (i_tx_ready),
      .o_tx_valid (tx_valid_w),
      .o_tx_data  (tx_data_w),
      .o_busy     (tx_busy)
   );

   // sequencer flops drive the pins: a second stage would split valid from the ready it sees
   assign o_tx_valid = tx_valid_w;
   assign o_tx_data  = tx_data_w;

   // packet capture and readout of payload into a local shadow
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q    <= ST_IDLE;
         id_q       <= 8'h00;
         len_q      <= 6'h00;
         rd_idx_q   <= 6'h00;
         rd_pend_q  <= 1'b0;
         over_q     <= 1'b0;
         o_rx_ready <= 1'b1;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               o_rx_ready <= 1'b1;
               if (i_rx_valid && i_rx_sop) begin
                  id_q   <= i_rx_data;
                  len_q  <= 6'h00;
                  over_q <= 1'b0;
                  if (i_rx_eop) begin
                     state_q    <= ST_EXEC;
                     o_rx_ready <= 1'b0;
                  end else begin
                     state_q <= ST_RECV;
                  end
               end
            end
            ST_RECV: begin
               if (i_rx_valid) begin
                  if (len_q < LEN_MAX) begin
                     len_q <= len_q + 6'h01;
                  end else begin
                     over_q <= 1'b1;
                  end
                  if (i_rx_eop) begin
                     state_q    <= ST_READ;
                     o_rx_ready <= 1'b0;
                     rd_idx_q   <= 6'h00;
                     rd_pend_q  <= 1'b0;
                  end
               end
            end
            ST_READ: begin
               // registered read: address and capture cycles alternate
               rd_pend_q <= !rd_pend_q;
               if (rd_pend_q) begin
                  if (rd_idx_q + 6'h01 >= len_q) begin
                     state_q <= ST_EXEC;
                  end else begin
                     rd_idx_q <= rd_idx_q + 6'h01;
                  end
               end
            end
            ST_EXEC: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (!tx_busy && !tx_load_q) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (state_q == ST_READ && rd_pend_q) begin
         rbuf[rd_idx_q[4:0]] <= buf_rdata;
      end
   end

   logic len_sgl;
   logic len_dbl;
   logic is_pos_cmd;
   logic pos_ok;
   assign len_sgl    = len_q == LEN_POS_SGL && !over_q;
   assign len_dbl    = len_q == LEN_POS_DBL && !over_q;
   assign is_pos_cmd = id_q == ID_POS_XYZ || id_q == ID_POS_LLA;
   // RULE21 length gate
   assign pos_ok     = state_q == ST_EXEC && is_pos_cmd && (len_sgl || len_dbl);

   function automatic logic [63:0] field(input int base, input logic dbl);
      logic [63:0] v;
      v = '0;
      if (dbl) begin
         for (int k = 0; k < 8; k++) begin
            v[63-8*k -: 8] = rbuf[base*2+k];
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            v[31-8*k -: 8] = rbuf[base+k];
         end
      end
      return v;
   endfunction

   // RULE5 cartesian, RULE9 geodetic, RULE6 either precision
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pos_valid     <= 1'b0;
         o_pos_is_lla    <= 1'b0;
         o_pos_is_double <= 1'b0;
         o_pos_a         <= '0;
         o_pos_b         <= '0;
         o_pos_c         <= '0;
      end else if (pos_ok) begin
         // RULE11 held as fixed location
         o_pos_valid     <= 1'b1;
         o_pos_is_lla    <= id_q == ID_POS_LLA;
         o_pos_is_double <= len_dbl;
         o_pos_a         <= field(0, len_dbl);
         o_pos_b         <= field(4, len_dbl);
         o_pos_c         <= field(8, len_dbl);
      end
   end

   // RULE7 abort survey, RULE8 over-determined mode
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_survey_abort   <= 1'b0;
         o_od_timing_mode <= 1'b0;
      end else begin
         o_survey_abort <= pos_ok && i_survey_active;
         if (pos_ok) begin
            o_od_timing_mode <= 1'b1;
         end
      end
   end

   // RULE3 base week date
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rollover_load            <= 1'b0;
         o_week_rollover_base_year  <= YEAR_RST;
         o_week_rollover_base_mdhms <= '0;
      end else begin
         o_rollover_load <= 1'b0;
         if (state_q == ST_EXEC && id_q == ID_ROLLOVER && len_q == LEN_ROLLOVER) begin
            o_rollover_load            <= 1'b1;
            o_week_rollover_base_year  <= {rbuf[0], rbuf[1]};
            o_week_rollover_base_mdhms <= {rbuf[2], rbuf[3], rbuf[4], rbuf[5], rbuf[6]};
         end
      end
   end

   // RULE13 apply four option bytes; RULE14 RULE15 reserved bits forced zero
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_opt_position  <= POS_RST;
         o_opt_velocity  <= VEL_RST;
         o_opt_timing    <= TIM_RST;
         o_opt_auxiliary <= AUX_RST;
      end else if (state_q == ST_EXEC && id_q == ID_IO_OPT && len_q == LEN_IO_OPT) begin
         o_opt_position  <= rbuf[0] & POS_MASK;
         o_opt_velocity  <= rbuf[1] & VEL_MASK;
         o_opt_timing    <= rbuf[2] & TIM_MASK;
         o_opt_auxiliary <= rbuf[3] & AUX_MASK;
      end
   end

   // RULE17 flash save only on the save command
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_opt_save <= 1'b0;
      end else begin
         o_opt_save <= state_q == ST_EXEC && id_q == ID_SAVE && len_q != 6'h00 && rbuf[0] == SUB_SAVE;
      end
   end

   // RULE19 RULE20 satellite request validity
   logic sat_ok;
   assign sat_ok = state_q == ST_EXEC && id_q == ID_SAT_REQ && len_q == LEN_SAT_REQ
                   && rbuf[0] == SAT_OP_REQ && rbuf[1] >= SAT_TYPE_MIN && rbuf[1] <= SAT_TYPE_MAX
                   && (rbuf[2] <= SAT_PRN_MAX
                       || (rbuf[2] == SAT_ALL && (rbuf[1] == SAT_ALMANAC || rbuf[1] == SAT_EPHEM)));

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_sat_req  <= 1'b0;
         o_sat_type <= 8'h00;
         o_sat_prn  <= 8'h00;
         o_sat_all  <= 1'b0;
      end else begin
         o_sat_req <= sat_ok;
         if (sat_ok) begin
            o_sat_type <= rbuf[1];
            o_sat_prn  <= rbuf[2];
            o_sat_all  <= rbuf[2] == SAT_ALL;
         end
      end
   end

   // aiding requests held until the sequencer is free; set wins over the send
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         aid_time_pend_q <= 1'b0;
         aid_pos_pend_q  <= 1'b0;
      end else begin
         if (i_aid_mode && i_aid_time_go) begin
            aid_time_pend_q <= 1'b1;
         end else if (state_q == ST_IDLE && !tx_busy && !tx_load_q && !i_rx_valid) begin
            aid_time_pend_q <= 1'b0;
         end
         if (i_aid_mode && i_aid_pos_go) begin
            aid_pos_pend_q <= 1'b1;
         end else if (state_q == ST_IDLE && !tx_busy && !tx_load_q && !i_rx_valid && !aid_time_pend_q) begin
            aid_pos_pend_q <= 1'b0;
         end
      end
   end

   // RULE18 disabled reports squeezed out, 57 last
   logic [31:0] last_ids;
   logic [3:0]  last_en;
   logic [47:0] last_list;
   logic [2:0]  last_count;
   assign last_ids = {ID_VEL_ENU, ID_VEL_XYZ,
                      o_opt_position[POS_DBL_BIT] ? ID_LLA_DBL : ID_LLA_SGL,
                      o_opt_position[POS_DBL_BIT] ? ID_XYZ_DBL : ID_XYZ_SGL};
   assign last_en  = {o_opt_velocity[VEL_ENU_BIT], o_opt_velocity[VEL_XYZ_BIT],
                      o_opt_position[POS_LLA_BIT], o_opt_position[POS_XYZ_BIT]};
   always_comb begin
      last_list  = '0;
      last_count = 3'h0;
      for (int k = 0; k < 4; k++) begin
         if (last_en[k]) begin
            last_list[8*last_count +: 8] = last_ids[8*k +: 8];
            last_count                   = last_count + 3'h1;
         end
      end
      last_list[8*last_count +: 8] = ID_LAST_REPORT;
      last_count                   = last_count + 3'h1;
   end

   // reply id lists, first byte in the low lane
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         tx_load_q  <= 1'b0;
         tx_list_q  <= '0;
         tx_count_q <= 3'h0;
      end else begin
         tx_load_q <= 1'b0;
         if (state_q == ST_EXEC) begin
            if (id_q == ID_IO_OPT && (len_q == 6'h00 || len_q == LEN_IO_OPT)) begin
               // RULE12 RULE13 options report
               tx_load_q  <= 1'b1;
               tx_list_q  <= {40'h0, ID_OPT_REPORT};
               tx_count_q <= 3'h1;
            end else if (id_q == ID_LAST_POS && len_q == 6'h00) begin
               // RULE18 enabled reports then 57
               tx_load_q  <= 1'b1;
               tx_list_q  <= last_list;
               tx_count_q <= last_count;
            end else if (sat_ok) begin
               tx_load_q  <= 1'b1;
               tx_list_q  <= {40'h0, ID_SAT_REPORT};
               tx_count_q <= 3'h1;
            end
         end else if (state_q == ST_IDLE && !tx_busy && !tx_load_q && !i_rx_valid) begin
            if (aid_time_pend_q) begin
               // RULE1 time request
               tx_load_q  <= 1'b1;
               tx_list_q  <= {32'h0, SUB_REQ, ID_TIME_REQ};
               tx_count_q <= 3'h2;
            end else if (aid_pos_pend_q) begin
               // RULE2 position request
               tx_load_q  <= 1'b1;
               tx_list_q  <= {32'h0, SUB_REQ, ID_POS_REQ};
               tx_count_q <= 3'h2;
            end
         end
      end
   end

   // RULE8 timing mode follows every accepted position
   a_od_mode_set: assert property (@(posedge i_clock) disable iff (i_rst)
      pos_ok |=> o_od_timing_mode) // RULE8
      else $error("timing mode not forced by position command");
   a_abort_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
      o_survey_abort |-> $past(pos_ok) && $past(i_survey_active)) // RULE7
      else $error("survey abort without position command");
   a_bad_len_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == ST_EXEC && is_pos_cmd && !len_sgl && !len_dbl) |=> $stable(o_pos_a) && !o_survey_abort) // RULE21
      else $error("bad length position command acted on");
   a_opt_reserved: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_opt_position & ~POS_MASK) == 8'h00 && (o_opt_velocity & ~VEL_MASK) == 8'h00) // RULE14
      else $error("reserved option bits set");
   a_opt_query_keep: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == ST_EXEC && id_q == ID_IO_OPT && len_q == 6'h00) |=> $stable(o_opt_position)) // RULE12
      else $error("option query changed states");
   a_aux_reserved: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_opt_auxiliary & ~AUX_MASK) == 8'h00) // RULE15
      else $error("reserved auxiliary bits set");
   a_save_cause: assert property (@(posedge i_clock) disable iff (i_rst)
      o_opt_save |-> $past(id_q) == ID_SAVE) // RULE17
      else $error("save without save command");
   a_sat_op: assert property (@(posedge i_clock) disable iff (i_rst)
      o_sat_req |=> o_sat_type >= SAT_TYPE_MIN && o_sat_type <= SAT_TYPE_MAX) // RULE19
      else $error("satellite request with bad type");
   a_sat_prn: assert property (@(posedge i_clock) disable iff (i_rst)
      o_sat_req |=> (o_sat_prn <= SAT_PRN_MAX || o_sat_all)) // RULE20
      else $error("satellite request with bad selector");
   a_roll_load: assert property (@(posedge i_clock) disable iff (i_rst)
      o_rollover_load |-> $past(id_q) == ID_ROLLOVER) // RULE3
      else $error("rollover loaded without command");
   a_time_req: assert property (@(posedge i_clock) disable iff (i_rst)
      (tx_load_q && tx_count_q == 3'h2 && tx_list_q[7:0] == ID_TIME_REQ) |-> tx_list_q[15:8] == SUB_REQ) // RULE1
      else $error("time request subidentifier wrong");
endmodule // gacd_decoder

//--- gacd_decoder_tb.sv
// command sequences against the decoder, checked at its ports
// assumes gacd_host_sink as the host side of the reply link
`timescale 1ns/1ps
module gacd_decoder_tb;
   import gacd_pkg::*;
   logic i_clock = 0, i_rst = 1, i_rx_valid = 0, i_rx_sop = 0, i_rx_eop = 0;
   logic i_aid_mode = 0, i_aid_time_go = 0, i_aid_pos_go = 0, i_survey_active = 0;
   logic i_tx_ready, i_stall = 0, o_tx_valid, o_rx_ready, o_survey_abort, o_od_timing_mode;
   logic o_pos_valid, o_pos_is_lla, o_pos_is_double, o_rollover_load, o_opt_save, o_sat_req, o_sat_all;
   logic [7:0]  i_rx_data = 0, o_tx_data, o_opt_position, o_opt_velocity, o_opt_timing;
   logic [7:0]  o_opt_auxiliary, o_sat_type, o_sat_prn, pkt[$];
   logic [63:0] o_pos_a, o_pos_b, o_pos_c;
   logic [15:0] o_week_rollover_base_year;
   logic [39:0] o_week_rollover_base_mdhms;
   int n_mismatch = 0, comparisons = 0, n_abort = 0, n_roll = 0, n_save = 0, n_sat = 0;
   always #5 i_clock = !i_clock;
   gacd_decoder u_gacd_decoder (.i_clock, .i_rst, .i_rx_valid, .i_rx_sop, .i_rx_eop, .i_rx_data,
      .i_tx_ready, .i_aid_mode, .i_aid_time_go, .i_aid_pos_go, .i_survey_active, .o_tx_valid,
      .o_tx_data, .o_rx_ready, .o_survey_abort, .o_od_timing_mode, .o_pos_valid, .o_pos_is_lla,
      .o_pos_is_double, .o_pos_a, .o_pos_b, .o_pos_c, .o_rollover_load, .o_week_rollover_base_year,
      .o_week_rollover_base_mdhms, .o_opt_position, .o_opt_velocity, .o_opt_timing,
      .o_opt_auxiliary, .o_opt_save, .o_sat_req, .o_sat_type, .o_sat_prn, .o_sat_all);
   gacd_host_sink u_gacd_host_sink (.i_clock, .i_stall, .i_tx_valid(o_tx_valid),
      .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
   always @(posedge i_clock) begin
      n_abort += (o_survey_abort === 1'b1);
      n_roll  += (o_rollover_load === 1'b1);
      n_save  += (o_opt_save === 1'b1);
      n_sat   += (o_sat_req === 1'b1);
   end
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one packet, then wait until replies are out
   task automatic send();
      int k;
      u_gacd_host_sink.got.delete();
      foreach (pkt[i]) begin
         i_rx_valid = 1'b1;
         i_rx_sop = (i == 0);
         i_rx_eop = (i == pkt.size() - 1);
         i_rx_data = pkt[i];
         @(negedge i_clock);
      end
      i_rx_valid = 1'b0;
      i_rx_sop = 1'b0;
      i_rx_eop = 1'b0;
      repeat (3) @(negedge i_clock);
      for (k = 0; k < 300 && o_rx_ready !== 1'b1; k++) @(negedge i_clock);
      if (k == 300) chk("rx ready back", 1'b0, 1'b1);
      repeat (30) @(negedge i_clock);
   endtask
   task automatic tx(input logic [7:0] last, input int n);
      chk("tx count", u_gacd_host_sink.got.size(), n);
      chk("tx last", u_gacd_host_sink.got[$], last);
   endtask
   task automatic aid(input logic m, input logic p, input logic [7:0] id);
      u_gacd_host_sink.got.delete();
      i_aid_mode = m;
      i_aid_time_go = !p;
      i_aid_pos_go = p;
      @(negedge i_clock);
      i_aid_time_go = 1'b0;
      i_aid_pos_go = 1'b0;
      repeat (40) @(negedge i_clock);
      chk("aid count", u_gacd_host_sink.got.size(), m ? 2 : 0);
      if (m) chk("aid bytes", {u_gacd_host_sink.got[0], u_gacd_host_sink.got[1]}, {id, SUB_REQ});
   endtask
   // span of all tests with generous margin
   initial begin
      #200us;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge i_clock);
      @(negedge i_clock) i_rst = 1'b0;
      i_stall = 1'b1;
      // geoid altitude selected, host keeps world datum
      pkt = {ID_IO_OPT, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      send();
      chk("opt pos", o_opt_position, 8'h17);
      chk("opt vel/tim/aux", {o_opt_velocity, o_opt_timing, o_opt_auxiliary}, 24'h03_0109);
      tx(ID_OPT_REPORT, 1);
      pkt = {ID_IO_OPT};
      send();
      chk("opt kept", o_opt_position, 8'h17);
      tx(ID_OPT_REPORT, 1);
      chk("no save yet", n_save, 0);
      pkt = {ID_SAVE, SUB_SAVE};
      send();
      chk("save pulse", n_save, 1);
      $display("test options done");
      pkt = {ID_ROLLOVER, 8'h07, 8'hEA, 8'h0C, 8'h1F, 8'h17, 8'h3B, 8'h3B};
      send();
      chk("base year", o_week_rollover_base_year, 16'h07EA);
      chk("base mdhms", o_week_rollover_base_mdhms, 40'h0C_1F17_3B3B);
      chk("base load", n_roll, 1);
      $display("test rollover done");
      chk("od mode idle", o_od_timing_mode, 1'b0);
      i_survey_active = 1'b1;
      pkt = {ID_POS_XYZ};
      for (int i = 0; i < 12; i++) pkt.push_back(8'(8'h10 + i));
      send();
      chk("abort", n_abort, 1);
      chk("od mode", o_od_timing_mode, 1'b1);
      chk("pos x/z", {o_pos_a[31:0], o_pos_c[31:0]}, 64'h1011_1213_1819_1A1B);
      chk("pos kind", {o_pos_valid, o_pos_is_lla, o_pos_is_double}, 3'b100);
      pkt = {ID_POS_LLA};
      for (int i = 0; i < 24; i++) pkt.push_back(8'(8'h40 + i));
      send();
      chk("lla kind", {o_pos_valid, o_pos_is_lla, o_pos_is_double}, 3'b111);
      chk("lla alt", o_pos_c, 64'h5051_5253_5455_5657);
      chk("lla lon", o_pos_b, 64'h4849_4A4B_4C4D_4E4F);
      chk("abort again", n_abort, 2);
      pkt = {ID_POS_XYZ, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
      send();
      chk("short pos", {n_abort[3:0], o_pos_is_lla, o_pos_is_double}, 6'h0B);
      $display("test position done");
      pkt = {ID_LAST_POS};
      send();
      tx(ID_LAST_REPORT, 5);
      chk("first report", u_gacd_host_sink.got[0], ID_XYZ_DBL);
      pkt = {ID_IO_OPT, 8'h02, 8'h02, 8'h00, 8'h00};
      send();
      pkt = {ID_LAST_POS};
      send();
      tx(ID_LAST_REPORT, 3);
      chk("first enabled", u_gacd_host_sink.got[0], ID_LLA_SGL);
      $display("test last position done");
      for (int t = 2; t <= 6; t++) begin
         pkt = {ID_SAT_REQ, SAT_OP_REQ, 8'(t), 8'((t - 2) * 8)};
         send();
         chk("sat type/prn", {o_sat_type, o_sat_prn, 7'h00, o_sat_all}, {8'(t), 8'((t - 2) * 8), 8'h00});
         tx(ID_SAT_REPORT, 1);
      end
      pkt = {ID_SAT_REQ, SAT_OP_REQ, SAT_EPHEM, SAT_ALL};
      send();
      chk("sat all", {o_sat_all, n_sat[3:0]}, 5'h16);
      $display("test satellite done");
      i_stall = 1'b0;
      aid(1'b0, 1'b0, ID_TIME_REQ);
      aid(1'b1, 1'b0, ID_TIME_REQ);
      aid(1'b1, 1'b1, ID_POS_REQ);
      $display("test aiding done");
      end_of_test();
   end
endmodule // gacd_decoder_tb

//--- gacd_host_sink.sv
// host model: takes reply and request bytes, records them
// assumes one byte per cycle under valid/ready
`timescale 1ns/1ps
module gacd_host_sink (
   input  wire logic       i_clock,
   input  wire logic       i_stall,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready
);
   logic       ph_q = 1'b0;
   logic [7:0] got[$];
   // slow host accepts every other cycle only while i_stall is high, every cycle otherwise
   always @(posedge i_clock) begin
      ph_q <= !ph_q;
      if (i_tx_valid && o_tx_ready)
         got.push_back(i_tx_data);
   end
   assign o_tx_ready = !i_stall || ph_q;
endmodule // gacd_host_sink

//--- gacd_pkg.sv
// package for the aiding command decoder: packet ids, field layouts, lengths, reset values
// assumes byte-framed packets with checksums and framing stripped upstream
package gacd_pkg;
   localparam logic [7:0] ID_TIME_REQ     = 8'h2E;
   localparam logic [7:0] ID_POS_REQ      = 8'h32;
   localparam logic [7:0] SUB_REQ         = 8'h00;
   localparam logic [7:0] ID_ROLLOVER     = 8'h30;
   localparam logic [7:0] ID_POS_XYZ      = 8'h31;
   localparam logic [7:0] ID_POS_LLA      = 8'h32;
   localparam logic [7:0] ID_IO_OPT       = 8'h35;
   localparam logic [7:0] ID_LAST_POS     = 8'h37;
   localparam logic [7:0] ID_SAT_REQ      = 8'h38;
   localparam logic [7:0] ID_SAVE         = 8'h8E;
   localparam logic [7:0] SUB_SAVE        = 8'h26;
   localparam logic [7:0] ID_OPT_REPORT   = 8'h55;
   localparam logic [7:0] ID_LAST_REPORT  = 8'h57;
   localparam logic [7:0] ID_SAT_REPORT   = 8'h58;
   localparam logic [7:0] ID_XYZ_SGL      = 8'h42;
   localparam logic [7:0] ID_LLA_SGL      = 8'h4A;
   localparam logic [7:0] ID_XYZ_DBL      = 8'h83;
   localparam logic [7:0] ID_LLA_DBL      = 8'h84;
   localparam logic [7:0] ID_VEL_XYZ      = 8'h43;
   localparam logic [7:0] ID_VEL_ENU      = 8'h56;
   // payload lengths, bytes after the id
   localparam logic [5:0] LEN_ROLLOVER    = 6'h07;
   localparam logic [5:0] LEN_POS_SGL     = 6'h0C;
   localparam logic [5:0] LEN_POS_DBL     = 6'h18;
   localparam logic [5:0] LEN_IO_OPT      = 6'h04;
   localparam logic [5:0] LEN_SAT_REQ     = 6'h03;
   localparam logic [5:0] LEN_MAX         = 6'h18;
   // option byte fields
   localparam int POS_XYZ_BIT  = 0;
   localparam int POS_LLA_BIT  = 1;
   localparam int POS_MSL_BIT  = 2;
   localparam int POS_DBL_BIT  = 4;
   localparam int VEL_XYZ_BIT  = 0;
   localparam int VEL_ENU_BIT  = 1;
   localparam int AUX_5A_BIT   = 0;
   localparam int AUX_DBHZ_BIT = 3;
   localparam logic [7:0] POS_MASK  = 8'h17;
   localparam logic [7:0] VEL_MASK  = 8'h03;
   localparam logic [7:0] TIM_MASK  = 8'h01;
   localparam logic [7:0] AUX_MASK  = 8'h09;
   localparam logic [7:0] POS_RST   = 8'h00;
   localparam logic [7:0] VEL_RST   = 8'h00;
   localparam logic [7:0] TIM_RST   = 8'h00;
   localparam logic [7:0] AUX_RST   = 8'h00;
   // satellite request fields
   localparam logic [7:0] SAT_OP_REQ   = 8'h01;
   localparam logic [7:0] SAT_TYPE_MIN = 8'h02;
   localparam logic [7:0] SAT_TYPE_MAX = 8'h06;
   localparam logic [7:0] SAT_ALMANAC  = 8'h02;
   localparam logic [7:0] SAT_EPHEM    = 8'h06;
   localparam logic [7:0] SAT_PRN_MAX  = 8'h20;
   localparam logic [7:0] SAT_ALL      = 8'hFF;
   localparam logic [15:0] YEAR_RST    = 16'h0000;
   localparam int OUT_MAX = 6;
endpackage

//--- gacd_rx_buf.sv
// payload byte store with registered read port
// assumes writes and reads never collide in meaning within one cycle
`timescale 1ns/1ps
module gacd_rx_buf
   import gacd_pkg::*;
#(
   parameter int DEPTH = 24,
   parameter int AW    = 5
) (
   input  wire logic          i_clock,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [7:0]    i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [7:0]    o_rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule // gacd_rx_buf

//--- gacd_tx_seq.sv
// outgoing packet id sequencer: plays a list of ids one per accepted byte
// assumes the sink holds i_tx_ready high whenever it can take a byte
`timescale 1ns/1ps
module gacd_tx_seq
   import gacd_pkg::*;
(
   input  wire logic                    i_clock,
   input  wire logic                    i_rst,
   input  wire logic                    i_load,
   input  wire logic [OUT_MAX*8-1:0]    i_list,
   input  wire logic [2:0]              i_count,
   input  wire logic                    i_tx_ready,
   output logic                         o_tx_valid,
   output logic      [7:0]              o_tx_data,
   output logic                         o_busy
);
   logic [OUT_MAX*8-1:0] list_q;
   logic [2:0]           left_q;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         list_q     <= '0;
         left_q     <= 3'h0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
      end else if (i_load && left_q == 3'h0 && !o_tx_valid) begin
         list_q <= i_list;
         left_q <= i_count;
      end else if (!o_tx_valid || i_tx_ready) begin
         if (left_q != 3'h0) begin
            o_tx_valid <= 1'b1;
            o_tx_data  <= list_q[7:0];
            list_q     <= list_q >> 8;
            left_q     <= left_q - 3'h1;
         end else begin
            o_tx_valid <= 1'b0;
         end
      end
   end

   assign o_busy = (left_q != 3'h0) || o_tx_valid;
endmodule // gacd_tx_seq
